// *** sdci_pkg.sv ***
// constants and types for the sdram command interface and initialization block
// Behaviour
// - address lines carry 11-bit row on activate, 8-bit column on read/write
// - bank select picks bank to open on activate, bank to access on read/write
// - chip select high disables decoder; running burst continues undisturbed
// - command decoded from row strobe, column strobe and write enable at one edge
// - read byte mask high tri-states that output byte two cycles later
// - write byte mask high blocks that byte's write in the same cycle
// - all inputs sampled only on the rising clock edge
// - clock gate low enters power down, clock suspend or self refresh
// - mode register undefined after power up; no access until programmed
// - mode set is all four strobes low; address lines give new parameters
// - mode register supports read latency of two or three cycles
// - mode register supports burst of one, two, four, eight words, full page
package sdci_pkg;
	localparam int ROW_W    = 11;
	localparam int COL_W    = 8;
	localparam int DATA_W   = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_W   = 1 + ROW_W + COL_W + 2 + DATA_W;

	// command codes as {rowStrobeN, colStrobeN, writeEnableN}
	localparam logic [2:0] CMD_MODE_SET  = 3'h0;
	localparam logic [2:0] CMD_REFRESH   = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
	localparam logic [2:0] CMD_WRITE     = 3'h4;
	localparam logic [2:0] CMD_READ      = 3'h5;
	localparam logic [2:0] CMD_STOP      = 3'h6;

	localparam int PRECHARGE_ALL_BIT = 10;

	// mode register fields
	localparam int BL_LSB      = 0;
	localparam int BT_BIT      = 3;
	localparam int CL_LSB      = 4;
	localparam logic [10:0] MODE_RST = 11'h000;
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [2:0] CL_2    = 3'h2;
	localparam logic [2:0] CL_3    = 3'h3;

	localparam logic [3:0] INIT_REFRESH_COUNT = 4'h8;

	typedef enum logic [1:0] {PWR_AWAKE, PWR_DOWN, PWR_SUSPEND, PWR_SELF_REFRESH} sdci_power_e;
	typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} sdci_burst_e;
endpackage : sdci_pkg

// *** sdci_fifo.sv ***
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module sdci_fifo #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_q;
	logic [AW:0]      rdPtr_q;

	wire empty = (wrPtr_q == rdPtr_q);
	wire full  = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
	wire push  = inValid && !full;
	wire pop   = !empty && outReady;

	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rdPtr_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (srst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
		end
	end

	// storage needs no reset; pointers alone define contents
	always_ff @(posedge clk) begin
		if (push)
			mem[wrPtr_q[AW-1:0]] <= inData;
	end

	fifo_level_a: assert property (@(posedge clk) disable iff (srst)
		full |=> wrPtr_q == $past(wrPtr_q))
		else $error("fifo pointer moved while full");
endmodule : sdci_fifo

// *** sdci_cmd_if.sv ***
// sdram command decoder, mode register, bank state, burst sequencer and data masking
`timescale 1ns/1ps
module sdci_cmd_if
	import sdci_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              csN,
	input  wire logic              rasN,
	input  wire logic              casN,
	input  wire logic              weN,
	input  wire logic              bankSel,
	input  wire logic [ROW_W-1:0]  addressLines,
	input  wire logic              upperByteMask,
	input  wire logic              lowerByteMask,
	input  wire logic              clockGate,
	input  wire logic [DATA_W-1:0] dataLinesIn,
	output logic [DATA_W-1:0]      dataLinesOut_q,
	output logic [1:0]             dataLinesOe_q,
	output logic                   coreRdReq_q,
	output logic                   coreRdBank_q,
	output logic [ROW_W-1:0]       coreRdRow_q,
	output logic [COL_W-1:0]       coreRdCol_q,
	input  wire logic [DATA_W-1:0] coreRdData,
	output logic                   coreWrValid_q,
	input  wire logic              coreWrReady,
	output logic [FIFO_W-1:0]      coreWrWord_q,
	output logic                   wrBufReady_q,
	output logic [ROW_W-1:0]       modeReg_q,
	output logic                   modeValid_q,
	output logic                   modeError_q,
	output logic                   initDone_q,
	output logic [1:0]             bankOpen_q,
	output sdci_power_e            powerState_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sdci_burst_e       burst_q;
	logic [COL_W-1:0]  startCol_q;
	logic [COL_W-1:0]  beat_q;
	logic              burstBank_q;
	logic [ROW_W-1:0]  rowAddr_q [2];
	logic [3:0]        refreshCnt_q;
	logic              rdS1Valid_q;
	logic              rdS2Valid_q;
	logic [DATA_W-1:0] rdS1Data_q;
	logic [DATA_W-1:0] rdS2Data_q;
	logic [1:0]        dqmD1_q;
	logic [1:0]        dqmD2_q;

	// command decode; a gated clock also blanks the decoder
	wire       cmdSel   = !csN && clockGate;
	wire [2:0] cmd      = {rasN, casN, weN};
	wire       banksIdle = (bankOpen_q == 2'b00);
	wire       isMrs    = cmdSel && cmd == CMD_MODE_SET && banksIdle;
	wire       isRef    = cmdSel && cmd == CMD_REFRESH && banksIdle;
	wire       isPre    = cmdSel && cmd == CMD_PRECHARGE;
	wire       isAct    = cmdSel && cmd == CMD_ACTIVATE && !bankOpen_q[bankSel];
	wire       isStop   = cmdSel && cmd == CMD_STOP;
	wire       accessOk = modeValid_q && bankOpen_q[bankSel];
	wire       newRd    = cmdSel && cmd == CMD_READ && accessOk;
	wire       newWr    = cmdSel && cmd == CMD_WRITE && accessOk;

	// mode fields
	wire [2:0] blCode     = modeReg_q[BL_LSB +: 3];
	wire       interleave = modeReg_q[BT_BIT];
	wire [2:0] clCode     = modeReg_q[CL_LSB +: 3];
	wire       cl3        = (clCode != CL_2);
	wire       blLegal    = (addressLines[BL_LSB +: 3] <= BL_8) || (addressLines[BL_LSB +: 3] == BL_FULL);
	wire       clLegal    = (addressLines[CL_LSB +: 3] == CL_2) || (addressLines[CL_LSB +: 3] == CL_3);
	logic [COL_W-1:0] blMask;
	always_comb begin
		case (blCode)
			BL_1:    blMask = 8'h00;
			BL_2:    blMask = 8'h01;
			BL_4:    blMask = 8'h03;
			BL_8:    blMask = 8'h07;
			default: blMask = 8'hff;
		endcase
	end

	// burst sequencing; suspend freezes the beat counter
	wire              contBeat = burst_q != BURST_IDLE && clockGate && !newRd && !newWr && !isStop && !isPre;
	wire              newAcc   = newRd || newWr;
	wire [COL_W-1:0]  beatIdx  = newAcc ? 8'h00 : beat_q;
	wire              lastBeat = (blCode != BL_FULL) && (beatIdx == blMask);
	wire [COL_W-1:0]  seqCol   = (startCol_q & ~blMask) | ((startCol_q + beat_q) & blMask);
	wire [COL_W-1:0]  runCol   = interleave ? (startCol_q ^ beat_q) : seqCol;
	wire [COL_W-1:0]  beatCol  = newAcc ? addressLines[COL_W-1:0] : runCol;
	wire              beatBank = newAcc ? bankSel : burstBank_q;
	wire              rdBeat   = newRd || (contBeat && burst_q == BURST_READ);
	wire              wrBeat   = newWr || (contBeat && burst_q == BURST_WRITE);

	// write path: masked bytes go to the core with their enable bit cleared; both masked means no entry
	wire [1:0]        byteMask  = {upperByteMask, lowerByteMask};
	wire              fifoInValid = wrBeat && byteMask != 2'b11;
	wire [FIFO_W-1:0] fifoInData  = {beatBank, rowAddr_q[beatBank], beatCol, ~byteMask, dataLinesIn};
	wire              fifoInReady;
	wire              fifoOutValid;
	wire [FIFO_W-1:0] fifoOutData;
	wire              fifoPop   = fifoOutValid && (!coreWrValid_q || coreWrReady);

	sdci_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) wrBuf (
		.clk      (clk),
		.srst     (srst),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOutData)
	);

	wire rdCapture = coreRdReq_q;

	// all state moves on the rising edge only
	always_ff @(posedge clk) begin
		if (srst) begin
			modeReg_q   <= MODE_RST;
			modeValid_q <= 1'b0;
			modeError_q <= 1'b0;
		end else if (isMrs) begin
			modeReg_q   <= addressLines;
			modeValid_q <= 1'b1;
			modeError_q <= !(blLegal && clLegal);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bankOpen_q   <= 2'b00;
			rowAddr_q[0] <= '0;
			rowAddr_q[1] <= '0;
		end else if (isAct) begin
			bankOpen_q[bankSel] <= 1'b1;
			rowAddr_q[bankSel]  <= addressLines;
		end else if (isPre) begin
			if (addressLines[PRECHARGE_ALL_BIT])
				bankOpen_q <= 2'b00;
			else
				bankOpen_q[bankSel] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			refreshCnt_q <= 4'h0;
			initDone_q   <= 1'b0;
		end else begin
			if (isRef && refreshCnt_q != INIT_REFRESH_COUNT)
				refreshCnt_q <= refreshCnt_q + 4'h1;
			initDone_q <= modeValid_q && refreshCnt_q == INIT_REFRESH_COUNT;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			burst_q     <= BURST_IDLE;
			startCol_q  <= '0;
			beat_q      <= '0;
			burstBank_q <= 1'b0;
		end else if (newAcc) begin
			burst_q     <= lastBeat ? BURST_IDLE : (newRd ? BURST_READ : BURST_WRITE);
			startCol_q  <= addressLines[COL_W-1:0];
			beat_q      <= 8'h01;
			burstBank_q <= bankSel;
		end else if (contBeat) begin
			if (lastBeat)
				burst_q <= BURST_IDLE;
			beat_q <= beat_q + 8'h01;
		end else if (isStop || isPre) begin
			burst_q <= BURST_IDLE;
		end
	end

	// low-power state chosen from what is running when the gate drops
	always_ff @(posedge clk) begin
		if (srst)
			powerState_q <= PWR_AWAKE;
		else if (clockGate)
			powerState_q <= PWR_AWAKE;
		else if (powerState_q == PWR_AWAKE) begin
			if (burst_q != BURST_IDLE)
				powerState_q <= PWR_SUSPEND;
			else if (!csN && cmd == CMD_REFRESH && banksIdle)
				powerState_q <= PWR_SELF_REFRESH;
			else
				powerState_q <= PWR_DOWN;
		end
	end

	// read path: core answers in the request cycle; stages pad to the latency
	always_ff @(posedge clk) begin
		if (srst) begin
			coreRdReq_q  <= 1'b0;
			coreRdBank_q <= 1'b0;
			coreRdRow_q  <= '0;
			coreRdCol_q  <= '0;
			rdS1Valid_q  <= 1'b0;
			rdS2Valid_q  <= 1'b0;
			rdS1Data_q   <= '0;
			rdS2Data_q   <= '0;
			dqmD1_q      <= 2'b11;
			dqmD2_q      <= 2'b11;
			dataLinesOut_q <= '0;
			dataLinesOe_q  <= 2'b00;
		end else begin
			coreRdReq_q  <= rdBeat;
			coreRdBank_q <= beatBank;
			coreRdRow_q  <= rowAddr_q[beatBank];
			coreRdCol_q  <= beatCol;
			rdS1Valid_q  <= rdCapture && cl3;
			rdS1Data_q   <= coreRdData;
			rdS2Valid_q  <= cl3 ? rdS1Valid_q : rdCapture;
			rdS2Data_q   <= cl3 ? rdS1Data_q : coreRdData;
			dqmD1_q      <= byteMask;
			dqmD2_q      <= dqmD1_q;
			dataLinesOut_q <= rdS2Data_q;
			dataLinesOe_q  <= {2{rdS2Valid_q}} & ~dqmD2_q;
		end
	end

	// one-deep output stage keeps the core-side write port registered
	always_ff @(posedge clk) begin
		if (srst) begin
			coreWrValid_q <= 1'b0;
			coreWrWord_q  <= '0;
			wrBufReady_q  <= 1'b0;
		end else begin
			wrBufReady_q <= fifoInReady;
			if (fifoPop) begin
				coreWrValid_q <= 1'b1;
				coreWrWord_q  <= fifoOutData;
			end else if (coreWrReady)
				coreWrValid_q <= 1'b0;
		end
	end

	mode_capture_a: assert property (isMrs |=> modeValid_q && modeReg_q == $past(addressLines))
		else $error("mode register not loaded from address lines");
	deselect_hold_a: assert property (csN |=> bankOpen_q == $past(bankOpen_q) && modeReg_q == $past(modeReg_q))
		else $error("deselected command changed state");
	read_mask_a: assert property (upperByteMask |-> ##3 !dataLinesOe_q[1])
		else $error("upper byte driven despite read mask");
	write_mask_a: assert property (wrBeat && upperByteMask && lowerByteMask |=> wrBuf.wrPtr_q == $past(wrBuf.wrPtr_q))
		else $error("fully masked write reached buffer");
	read_latency_a: assert property (coreRdReq_q && clCode == CL_3 |=> rdS1Valid_q ##1 rdS2Valid_q)
		else $error("read data not at latency three");
	burst_four_a: assert property ((newRd && blCode == BL_4) ##1 contBeat [*3] |=> burst_q == BURST_IDLE)
		else $error("four-word burst length wrong");
	suspend_freeze_a: assert property (burst_q != BURST_IDLE && !clockGate |=> beat_q == $past(beat_q))
		else $error("burst advanced with clock gated");
	no_mode_access_a: assert property (!modeValid_q |-> !rdBeat && !wrBeat)
		else $error("access before mode register set");
	activate_row_a: assert property (isAct |=> bankOpen_q[$past(bankSel)] && rowAddr_q[$past(bankSel)] == $past(addressLines))
		else $error("activate did not open bank with row");
	column_addr_a: assert property (newRd |=> coreRdCol_q == $past(addressLines[COL_W-1:0]))
		else $error("read column not taken from low address lines");
endmodule : sdci_cmd_if

// *** sdci_ctrl_model.sv ***
// behavioural memory controller driving command, mask, gate and write data pins
`timescale 1ns/1ps
module sdci_ctrl_model
	import sdci_pkg::*;
#(
	parameter int PAUSE_CYCLES    = 8000,
	parameter int RECOVERY_CYCLES = 2
) (
	input  wire logic         clk,
	output logic              csN,
	output logic              rasN,
	output logic              casN,
	output logic              weN,
	output logic              bankSel,
	output logic [ROW_W-1:0]  addressLines,
	output logic              upperByteMask,
	output logic              lowerByteMask,
	output logic              clockGate,
	output logic [DATA_W-1:0] dataLinesIn
);
	// no-operation, masks and gate high until the pause has run out
	initial begin
		{csN, rasN, casN, weN} = 4'h7;
		{bankSel, addressLines} = 12'h000;
		{upperByteMask, lowerByteMask, clockGate} = 3'h7;
		dataLinesIn = 16'h0000;
	end
	// drives at once; callers stand at a falling edge
	task automatic drive(input logic [2:0] code, input logic bank, input logic [ROW_W-1:0] addr, input logic desel);
		{csN, rasN, casN, weN} = {desel, code};
		bankSel = bank;
		addressLines = addr;
	endtask : drive
	task automatic put(input logic [DATA_W-1:0] d, input logic um, input logic lm, input logic gate);
		dataLinesIn = d;
		{upperByteMask, lowerByteMask, clockGate} = {um, lm, gate};
	endtask : put
	// address goes inverted afterwards so a stale value never looks valid
	task automatic cmd(input logic [2:0] code, input logic bank, input logic [ROW_W-1:0] addr, input logic desel);
		@(negedge clk);
		drive(code, bank, addr, desel);
		@(negedge clk);
		drive(3'h7, ~bank, ~addr, 1'b0);
	endtask : cmd
	task automatic init(input logic [ROW_W-1:0] mode, input int nRef);
		repeat (PAUSE_CYCLES) @(negedge clk);
		cmd(CMD_PRECHARGE, 1'b0, 11'h400, 1'b0);
		cmd(CMD_MODE_SET, 1'b0, mode, 1'b0);
		repeat (RECOVERY_CYCLES) @(negedge clk);
		repeat (nRef) cmd(CMD_REFRESH, 1'b0, 11'h000, 1'b0);
	endtask : init
endmodule : sdci_ctrl_model

// *** sdci_cmd_if_test.sv ***
// self-checking bench for the sdram command interface against a controller model
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((exp) !== (got)) begin err_count++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module sdci_cmd_if_test
	import sdci_pkg::*;
;
	logic              clk = 1'b0, srst, csN, rasN, casN, weN, bankSel, upperByteMask, lowerByteMask, clockGate;
	logic [ROW_W-1:0]  addressLines, coreRdRow_q, modeReg_q;
	logic [DATA_W-1:0] dataLinesIn, dataLinesOut_q, coreRdData;
	logic [1:0]        dataLinesOe_q, bankOpen_q;
	logic              coreRdReq_q, coreRdBank_q, coreWrValid_q, coreWrReady, wrBufReady_q;
	logic              modeValid_q, modeError_q, initDone_q;
	logic [COL_W-1:0]  coreRdCol_q;
	logic [FIFO_W-1:0] coreWrWord_q;
	sdci_power_e       powerState_q;
	int                err_count = 0;
	int                n_checks = 0;
	always #12.5 clk = ~clk;
	// core memory answers with a word that names its own column
	assign coreRdData = {coreRdCol_q, ~coreRdCol_q};
	sdci_cmd_if DUT (.clk, .srst, .csN, .rasN, .casN, .weN, .bankSel, .addressLines, .upperByteMask,
		.lowerByteMask, .clockGate, .dataLinesIn, .dataLinesOut_q, .dataLinesOe_q, .coreRdReq_q,
		.coreRdBank_q, .coreRdRow_q, .coreRdCol_q, .coreRdData, .coreWrValid_q, .coreWrReady,
		.coreWrWord_q, .wrBufReady_q, .modeReg_q, .modeValid_q, .modeError_q, .initDone_q,
		.bankOpen_q, .powerState_q);
	sdci_ctrl_model #(.PAUSE_CYCLES(8000), .RECOVERY_CYCLES(2)) ctl (.clk, .csN, .rasN, .casN,
		.weN, .bankSel, .addressLines, .upperByteMask, .lowerByteMask, .clockGate, .dataLinesIn);
	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic setup(input logic [ROW_W-1:0] mode);
		ctl.cmd(CMD_PRECHARGE, 1'b0, 11'h400, 1'b0);
		ctl.cmd(CMD_MODE_SET, 1'b0, mode, 1'b0);
		repeat (2) @(negedge clk);
		ctl.cmd(CMD_ACTIVATE, 1'b1, 11'h2a5, 1'b0);
		`CHK("modeReg", mode, modeReg_q)
		`CHK("bankOpen", 2'b10, bankOpen_q)
	endtask : setup
	task automatic rd_burst(input int bl, input int cl, input logic mu, input logic desel);
		logic [7:0] c;
		logic       on;
		ctl.put(16'h0000, mu, 1'b0, 1'b1);
		ctl.cmd(CMD_READ, 1'b1, 11'h010, 1'b0);
		for (int k = 0; k <= bl + cl; k++) begin
			c = 8'h10 + k[7:0];
			on = k >= cl && k < cl + bl;
			`CHK("rdReq", k < bl, coreRdReq_q)
			if (k < bl) `CHK("rdAddr", {1'b1, 11'h2a5, c}, {coreRdBank_q, coreRdRow_q, coreRdCol_q})
			`CHK("rdOe", {on & ~mu, on}, dataLinesOe_q)
			if (on) `CHK("rdData", {c - cl[7:0], ~(c - cl[7:0])}, dataLinesOut_q)
			// a deselected precharge must not cut the burst short
			ctl.drive(desel && k == 1 ? CMD_PRECHARGE : 3'h7, 1'b0, 11'h400, desel && k == 1);
			@(negedge clk);
		end
	endtask : rd_burst
	// start column 1 tells a wrapped count from a flipped bit
	task automatic t_order();
		for (int il = 0; il < 2; il++) begin
			setup({4'h0, CL_2, il[0], BL_4});
			`CHK("modeOk", 1'b0, modeError_q)
			ctl.cmd(CMD_READ, 1'b1, 11'h011, 1'b0);
			for (int k = 0; k < 4; k++) begin
				`CHK("burstCol", (il == 1) ? (8'h10 | (8'h01 ^ k[7:0])) : (8'h10 | ((8'h01 + k[7:0]) & 8'h03)), coreRdCol_q)
				@(negedge clk);
			end
		end
		setup({4'h0, 3'h5, 1'b0, BL_2});
		`CHK("modeError", 1'b1, modeError_q)
	endtask : t_order
	task automatic t_init();
		`CHK("resetOuts", 9'h000, {modeValid_q, initDone_q, bankOpen_q, coreRdReq_q, coreWrValid_q,
			modeError_q, dataLinesOe_q})
		`CHK("resetMode", MODE_RST, modeReg_q)
		`CHK("resetPwr", PWR_AWAKE, powerState_q)
		ctl.init({4'h0, CL_3, 1'b0, BL_4}, 7);
		@(negedge clk);
		`CHK("initEarly", 2'b01, {initDone_q, modeValid_q})
		ctl.cmd(CMD_REFRESH, 1'b0, 11'h000, 1'b0);
		@(negedge clk);
		`CHK("initDone", 1'b1, initDone_q)
	endtask : t_init
	task automatic t_reads();
		logic [2:0] blc [4] = '{BL_1, BL_2, BL_4, BL_8};
		for (int i = 0; i < 4; i++) begin
			setup({4'h0, (i % 2) ? CL_3 : CL_2, 1'b0, blc[i]});
			rd_burst(1 << i, (i % 2) ? 3 : 2, i == 2, i == 3);
		end
		setup({4'h0, CL_2, 1'b0, BL_FULL});
		ctl.cmd(CMD_READ, 1'b1, 11'h000, 1'b0);
		repeat (19) @(negedge clk);
		`CHK("fullPage", 1'b1, coreRdReq_q)
		ctl.put(16'h0000, 1'b0, 1'b0, 1'b0);
		@(negedge clk);
		`CHK("suspend", {PWR_SUSPEND, 1'b0}, {powerState_q, coreRdReq_q})
		ctl.put(16'h0000, 1'b0, 1'b0, 1'b1);
		@(negedge clk);
		`CHK("resumeCol", 8'h14, coreRdCol_q)
		ctl.cmd(CMD_STOP, 1'b1, 11'h000, 1'b0);
		`CHK("stopped", 1'b0, coreRdReq_q)
	endtask : t_reads
	task automatic t_write();
		int n;
		setup({4'h0, CL_2, 1'b0, BL_2});
		ctl.put(16'h1234, 1'b0, 1'b1, 1'b1);
		ctl.cmd(CMD_WRITE, 1'b1, 11'h020, 1'b0);
		ctl.put(16'h5678, 1'b1, 1'b1, 1'b1);
		@(negedge clk);
		ctl.put(16'h0000, 1'b0, 1'b0, 1'b1);
		coreWrReady = 1'b1;
		for (n = 0; n < 8 && coreWrValid_q !== 1'b1; n++) @(negedge clk);
		`CHK("wrWord", {1'b1, 11'h2a5, 8'h20, 2'b10, 16'h1234}, coreWrWord_q)
		@(negedge clk);
		`CHK("wrMasked", 1'b0, coreWrValid_q)
	endtask : t_write
	task automatic t_fill();
		int n = 0;
		setup({4'h0, CL_2, 1'b0, BL_FULL});
		coreWrReady = 1'b0;
		ctl.put(16'h0000, 1'b0, 1'b0, 1'b1);
		ctl.cmd(CMD_WRITE, 1'b1, 11'h000, 1'b0);
		for (int k = 1; k < 40; k++) begin
			ctl.put(k[15:0], 1'b0, 1'b0, 1'b1);
			@(negedge clk);
		end
		ctl.cmd(CMD_STOP, 1'b1, 11'h000, 1'b0);
		`CHK("bufFull", 1'b0, wrBufReady_q)
		coreWrReady = 1'b1;
		repeat (60) begin
			if (coreWrValid_q === 1'b1) begin
				`CHK("drain", n[15:0], coreWrWord_q[15:0])
				n++;
			end
			@(negedge clk);
		end
		`CHK("drained", FIFO_DEPTH + 1, n)
		`CHK("bufEmpty", 1'b1, wrBufReady_q)
	endtask : t_fill
	task automatic t_power();
		ctl.cmd(CMD_PRECHARGE, 1'b0, 11'h400, 1'b0);
		ctl.cmd(CMD_MODE_SET, 1'b0, 11'h7ff, 1'b1);
		`CHK("deselMode", 11'h027, modeReg_q)
		@(negedge clk);
		ctl.put(16'h0000, 1'b1, 1'b1, 1'b0);
		ctl.drive(CMD_MODE_SET, 1'b0, 11'h7ff, 1'b0);
		@(negedge clk);
		ctl.drive(3'h7, 1'b0, 11'h000, 1'b0);
		`CHK("pwrDown", PWR_DOWN, powerState_q)
		`CHK("gatedMode", 11'h027, modeReg_q)
		ctl.put(16'h0000, 1'b1, 1'b1, 1'b1);
		@(negedge clk);
		`CHK("awake", PWR_AWAKE, powerState_q)
		ctl.drive(CMD_REFRESH, 1'b0, 11'h000, 1'b0);
		ctl.put(16'h0000, 1'b1, 1'b1, 1'b0);
		@(negedge clk);
		ctl.drive(3'h7, 1'b0, 11'h000, 1'b0);
		`CHK("selfRef", PWR_SELF_REFRESH, powerState_q)
		ctl.put(16'h0000, 1'b1, 1'b1, 1'b1);
		@(negedge clk);
		`CHK("awake", PWR_AWAKE, powerState_q)
	endtask : t_power
	task automatic t_rereset();
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		`CHK("modeValid", 1'b0, modeValid_q)
		ctl.cmd(CMD_ACTIVATE, 1'b0, 11'h011, 1'b0);
		ctl.cmd(CMD_READ, 1'b0, 11'h000, 1'b0);
		`CHK("bankOpen", 2'b01, bankOpen_q)
		repeat (3) begin
			`CHK("noRead", 1'b0, coreRdReq_q)
			@(negedge clk);
		end
	endtask : t_rereset
	initial begin
		srst = 1'b1;
		coreWrReady = 1'b0;
		repeat (20) @(negedge clk);
		srst = 1'b0;
		t_init();
		t_order();
		t_reads();
		t_write();
		t_fill();
		t_power();
		t_rereset();
		wrap_up();
	end
	// the whole run is some 8300 cycles; a hang stops well after that
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end
endmodule : sdci_cmd_if_test
